// >>> src/pescc_pkg.sv
package pescc_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CHG_STATUS = 8'h01;
  localparam logic [7:0] ADDR_RAIL_STATUS = 8'h02;
  localparam logic [7:0] ADDR_CHG_MASK = 8'h03;
  localparam logic [7:0] ADDR_RAIL_MASK = 8'h04;
  localparam logic [7:0] ADDR_CHG_ACK = 8'h05;
  localparam logic [7:0] ADDR_RAIL_ACK = 8'h06;
  localparam logic [7:0] ADDR_SETUP = 8'h07;
  // values after reset
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_ACK = 8'h00;
  localparam logic [7:0] RST_SETUP = 8'h1B;
  localparam logic [7:0] RD_UNMAPPED = 8'hFF;
  // lid pin reads low while the synchroniser is still clear after reset
  localparam logic [7:0] RST_RAIL_PREV = 8'h40;
  // field layout
  localparam logic [7:0] CHG_EDGE_BITS = 8'h21;
  localparam logic [7:0] CHG_HOST_CLR_BITS = 8'h1E;
  localparam logic [7:0] CHG_FOLLOW_BITS = 8'hC0;
  localparam logic [7:0] RAIL_EDGE_BITS = 8'hE0;
  localparam int SETUP_POR_SHORT = 7;
  localparam int SETUP_RESTART = 6;
  localparam int SETUP_TMR_EN = 5;
  localparam int SETUP_CUR_MSB = 4;
  localparam int SETUP_CUR_LSB = 3;
  localparam int SETUP_USB_500 = 2;
  localparam int SETUP_USB_ALLOW = 1;
  localparam int SETUP_CHG_EN = 0;
  localparam int SRC_USB_VALID = 7;
  localparam int SRC_AC_VALID = 6;
  localparam int SRC_FAST_TMO = 2;
  localparam int SRC_TAPER_TMO = 3;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] RESET_LONG_MS = 10'h3E8;
  localparam logic [9:0] RESET_SHORT_MS = 10'h045;
endpackage

// >>> src/pescc_sync.sv
`timescale 1ns/100ps
module pescc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pescc_sync_t;

  pescc_sync_t st;
  pescc_sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.s2;
endmodule

// >>> src/pescc_top.sv
// Notes on behaviour
// - timeout bits 3,2 read 0 while charging, 1 after a timer expiry.
// - bit 0 reports battery temperature out of range, charging suspended.
// - host write clears charge bits 4..1 written as 0 and resets charger; others ignored.
// - any set charge bit pulls the interrupt low unless masked.
// - rail bit 7 sets when the shutdown button is operated.
// - rail bit 6 is the inverse of the battery lid pin.
// - rail bit 5 sets when supply falls below undervoltage threshold.
// - rail bit 4 always reads 0 and never interrupts.
// - rail bits 3,2 show linear regulator faults, 0 when disabled.
// - rail bits 1,0 show buck faults; bit 0 also core-off low power.
// - rising rail bit pulls the interrupt low unless masked.
// - charge mask is read-write, resets to all ones.
// - rail mask is read-write, resets to all ones.
// - acknowledged bits stop driving the interrupt; pin releases if none left.
// - acknowledge bits clear automatically once the status bit clears.
// - setup bit 7 picks reset pulse of 1000 ms or 69 ms.
// - setup bit 6 clears charger timers; host sets then clears it.
// - setup bit 5 enables fast-charge and taper timers, reset 0.
// - setup bits 4:3 choose charge current 25, 50, 75 or 100 percent.
// - setup bit 2 picks 100 or 500 mA USB, ignored if USB barred.
// - reading a set status bit sets its acknowledge bit.
// - rail bits 7..5 edge set, clear when low and acked; 3..0 follow.
// - setup bit 1 bars or permits charging from USB.
// - setup bit 0 enables charging, wall supply preferred over USB.
`timescale 1ns/100ps
module pescc_top #(
  parameter int TICK_CYCLES = pescc_pkg::MS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // register access from the serial slave
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // charger condition pins
  input  wire logic [7:0] charger_cond_in,
  // rail condition pins
  input  wire logic       shutdown_button_in,
  input  wire logic       battery_lid_sense_in,
  input  wire logic       supply_undervoltage_in,
  input  wire logic       linreg_b_fault_in,
  input  wire logic       linreg_a_fault_in,
  input  wire logic       io_buck_fault_in,
  input  wire logic       cpu_buck_fault_in,
  input  wire logic       low_power_mode_in,
  input  wire logic       reset_request_in,
  // settings held elsewhere on this clock
  input  wire logic       linreg_b_enable_in,
  input  wire logic       linreg_a_enable_in,
  input  wire logic       core_off_low_power_in,
  // interrupt and reset pulse
  output logic            event_int_n_out,
  output logic            reset_pulse_n_out,
  // charger controls
  output logic            charger_restart_out,
  output logic            safety_timer_en_out,
  output logic      [1:0] charge_current_sel_out,
  output logic            usb_500ma_out,
  output logic            charge_from_ac_out,
  output logic            charge_from_usb_out
);
  typedef enum logic [1:0] {
    RP_IDLE = 2'b00,
    RP_HOLD = 2'b01
  } pescc_rp_t;

  typedef struct packed {
    logic [7:0]  chg_status;
    logic [7:0]  rail_status;
    logic [7:0]  chg_mask;
    logic [7:0]  rail_mask;
    logic [7:0]  chg_ack;
    logic [7:0]  rail_ack;
    logic [7:0]  setup;
    logic [7:0]  chg_prev;
    logic [7:0]  rail_prev;
    logic [7:0]  rdata;
    logic        int_n;
    logic        restart;
    logic        req_prev;
    pescc_rp_t   rp;
    logic [16:0] tick;
    logic [9:0]  ms;
    logic        rp_n;
    logic        tmr_en;
    logic [1:0]  cur;
    logic        usb500;
    logic        from_ac;
    logic        from_usb;
  } pescc_state_t;

  pescc_state_t st;
  pescc_state_t next_st;

  logic [16:0] sync_raw;
  logic [16:0] sync_q;
  logic [7:0]  chg_src;
  logic [7:0]  rail_src;
  logic        lp_mode;
  logic        req_sync;

  // every pin source crosses two flops
  assign sync_raw = {reset_request_in, low_power_mode_in,
                     shutdown_button_in, battery_lid_sense_in,
                     supply_undervoltage_in, linreg_b_fault_in,
                     linreg_a_fault_in, io_buck_fault_in,
                     cpu_buck_fault_in, charger_cond_in};

  pescc_sync #(.W(17)) i_pescc_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .d_in     (sync_raw),
    .q_out    (sync_q)
  );

  function automatic logic [7:0] pescc_pend(input logic [7:0] s,
                                            input logic [7:0] m,
                                            input logic [7:0] a);
    pescc_pend = s & ~m & ~a;
  endfunction

  function automatic logic pescc_hit(input logic [7:0] a,
                                     input logic [7:0] r);
    pescc_hit = (a == r);
  endfunction

  always_comb begin
    req_sync = sync_q[16];
    lp_mode  = sync_q[15];
    chg_src  = sync_q[7:0];
    // timers disabled cannot time out
    chg_src[pescc_pkg::SRC_FAST_TMO] = sync_q[pescc_pkg::SRC_FAST_TMO]
                                       & st.setup[pescc_pkg::SETUP_TMR_EN];
    chg_src[pescc_pkg::SRC_TAPER_TMO] = sync_q[pescc_pkg::SRC_TAPER_TMO]
                                        & st.setup[pescc_pkg::SETUP_TMR_EN];
    rail_src[7] = sync_q[14];
    rail_src[6] = ~sync_q[13];
    rail_src[5] = sync_q[12];
    rail_src[4] = 1'b0;
    rail_src[3] = sync_q[11] & linreg_b_enable_in;
    rail_src[2] = sync_q[10] & linreg_a_enable_in;
    rail_src[1] = sync_q[9];
    rail_src[0] = sync_q[8] | (core_off_low_power_in & lp_mode);
  end

  logic [7:0] chg_rise;
  logic [7:0] rail_rise;
  logic [7:0] host_clr;
  logic       rd_chg;
  logic       rd_rail;

  always_comb begin
    chg_rise  = chg_src & ~st.chg_prev;
    rail_rise = rail_src & ~st.rail_prev;
    rd_chg    = reg_rd_in & pescc_hit(reg_addr_in, pescc_pkg::ADDR_CHG_STATUS);
    rd_rail   = reg_rd_in
                & pescc_hit(reg_addr_in, pescc_pkg::ADDR_RAIL_STATUS);
    host_clr  = 8'h00;
    if (reg_wr_in && pescc_hit(reg_addr_in, pescc_pkg::ADDR_CHG_STATUS)) begin
      host_clr = ~reg_wdata_in & pescc_pkg::CHG_HOST_CLR_BITS;
    end
  end

  always_comb begin
    next_st           = st;
    next_st.chg_prev  = chg_src;
    next_st.rail_prev = rail_src;
    next_st.restart   = 1'b0;
    next_st.req_prev  = req_sync;

    // edge bits: rise wins; clear when low and acked
    // bits 4..1 track their sources until host clear; bits 7,6 follow
    next_st.chg_status =
        (pescc_pkg::CHG_EDGE_BITS
         & (chg_rise | (st.chg_status & ~(~chg_src & st.chg_ack))))
      | (pescc_pkg::CHG_HOST_CLR_BITS
         & (chg_rise | (st.chg_status & chg_src & ~host_clr)))
      | (pescc_pkg::CHG_FOLLOW_BITS & chg_src);
    next_st.rail_status =
        (pescc_pkg::RAIL_EDGE_BITS
         & (rail_rise | (st.rail_status & ~(~rail_src & st.rail_ack))))
      | (~pescc_pkg::RAIL_EDGE_BITS & rail_src);

    // reading sets acks; acks fall with the status bit
    next_st.chg_ack  = (st.chg_ack | (rd_chg ? st.chg_status : 8'h00))
                       & next_st.chg_status;
    next_st.rail_ack = (st.rail_ack | (rd_rail ? st.rail_status : 8'h00))
                       & next_st.rail_status;

    // interrupt from unmasked, unacked bits
    next_st.int_n = ~|(pescc_pend(st.chg_status, st.chg_mask, st.chg_ack)
                       | pescc_pend(st.rail_status, st.rail_mask,
                                    st.rail_ack));

    if (reg_wr_in) begin
      case (reg_addr_in)
        pescc_pkg::ADDR_CHG_STATUS: begin
          next_st.restart = 1'b1;
        end
        pescc_pkg::ADDR_CHG_MASK: begin
          next_st.chg_mask = reg_wdata_in;
        end
        pescc_pkg::ADDR_RAIL_MASK: begin
          next_st.rail_mask = reg_wdata_in;
        end
        pescc_pkg::ADDR_SETUP: begin
          next_st.setup = reg_wdata_in;
          next_st.restart = reg_wdata_in[pescc_pkg::SETUP_RESTART];
        end
        default: begin
          next_st.setup = st.setup;
        end
      endcase
    end

    // snapshot at read start; new events still land
    if (reg_rd_in) begin
      case (reg_addr_in)
        pescc_pkg::ADDR_CHG_STATUS:  next_st.rdata = st.chg_status;
        pescc_pkg::ADDR_RAIL_STATUS: next_st.rdata = st.rail_status;
        pescc_pkg::ADDR_CHG_MASK:    next_st.rdata = st.chg_mask;
        pescc_pkg::ADDR_RAIL_MASK:   next_st.rdata = st.rail_mask;
        pescc_pkg::ADDR_CHG_ACK:     next_st.rdata = st.chg_ack;
        pescc_pkg::ADDR_RAIL_ACK:    next_st.rdata = st.rail_ack;
        pescc_pkg::ADDR_SETUP:       next_st.rdata = st.setup;
        default:                     next_st.rdata = pescc_pkg::RD_UNMAPPED;
      endcase
    end

    // charger controls from setup
    next_st.tmr_en = next_st.setup[pescc_pkg::SETUP_TMR_EN];
    next_st.cur = next_st.setup[pescc_pkg::SETUP_CUR_MSB:
                                pescc_pkg::SETUP_CUR_LSB];
    next_st.usb500 = next_st.setup[pescc_pkg::SETUP_USB_500]
                     & next_st.setup[pescc_pkg::SETUP_USB_ALLOW];
    next_st.from_ac = next_st.setup[pescc_pkg::SETUP_CHG_EN]
                      & chg_src[pescc_pkg::SRC_AC_VALID];
    next_st.from_usb = next_st.setup[pescc_pkg::SETUP_CHG_EN]
                       & next_st.setup[pescc_pkg::SETUP_USB_ALLOW]
                       & chg_src[pescc_pkg::SRC_USB_VALID]
                       & ~chg_src[pescc_pkg::SRC_AC_VALID];

    // reset pulse timed in ms ticks
    next_st.tick = (st.tick == 17'(TICK_CYCLES - 1)) ? 17'h00000
                   : 17'(st.tick + 17'h00001);
    case (st.rp)
      RP_IDLE: begin
        next_st.rp_n = 1'b1;
        if (req_sync && !st.req_prev) begin
          next_st.rp   = RP_HOLD;
          next_st.ms   = 10'h000;
          next_st.tick = 17'h00000;
          next_st.rp_n = 1'b0;
        end
      end
      RP_HOLD: begin
        next_st.rp_n = 1'b0;
        if (st.tick == 17'(TICK_CYCLES - 1)) begin
          next_st.ms = 10'(st.ms + 10'h001);
          if (10'(st.ms + 10'h001)
              == (st.setup[pescc_pkg::SETUP_POR_SHORT]
                  ? pescc_pkg::RESET_SHORT_MS
                  : pescc_pkg::RESET_LONG_MS)) begin
            next_st.rp   = RP_IDLE;
            next_st.rp_n = 1'b1;
          end
        end
      end
      default: begin
        next_st.rp   = RP_IDLE;
        next_st.rp_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st             <= '0;
      st.chg_mask    <= pescc_pkg::RST_MASK;
      st.rail_mask   <= pescc_pkg::RST_MASK;
      st.setup       <= pescc_pkg::RST_SETUP;
      st.chg_status  <= pescc_pkg::RST_STATUS;
      st.rail_status <= pescc_pkg::RST_STATUS;
      st.chg_ack     <= pescc_pkg::RST_ACK;
      st.rail_ack    <= pescc_pkg::RST_ACK;
      st.rail_prev   <= pescc_pkg::RST_RAIL_PREV;
      st.int_n       <= 1'b1;
      st.rp          <= RP_HOLD;
      st.rp_n        <= 1'b0;
      st.tmr_en      <= pescc_pkg::RST_SETUP[pescc_pkg::SETUP_TMR_EN];
      st.cur         <= pescc_pkg::RST_SETUP[pescc_pkg::SETUP_CUR_MSB:
                                             pescc_pkg::SETUP_CUR_LSB];
      st.usb500      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out          = st.rdata;
  assign event_int_n_out        = st.int_n;
  assign reset_pulse_n_out      = st.rp_n;
  assign charger_restart_out    = st.restart;
  assign safety_timer_en_out    = st.tmr_en;
  assign charge_current_sel_out = st.cur;
  assign usb_500ma_out          = st.usb500;
  assign charge_from_ac_out     = st.from_ac;
  assign charge_from_usb_out    = st.from_usb;

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_int_pending_low: assert property (
    |pescc_pend(st.chg_status, st.chg_mask, st.chg_ack) |=> !event_int_n_out)
    else $error("unmasked charge event did not pull interrupt low");
  a_int_release_high: assert property (
    !(|pescc_pend(st.chg_status, st.chg_mask, st.chg_ack))
    && !(|pescc_pend(st.rail_status, st.rail_mask, st.rail_ack))
    |=> event_int_n_out)
    else $error("interrupt held low with nothing pending");
  a_rail_bit4_zero: assert property (
    !st.rail_status[4] && !st.rail_ack[4])
    else $error("unimplemented rail bit is set");
  a_ack_subset: assert property (
    ((st.chg_ack & ~st.chg_status) == 8'h00)
    && ((st.rail_ack & ~st.rail_status) == 8'h00))
    else $error("acknowledge bit left without status bit");
  a_read_sets_ack: assert property (
    rd_rail |=> ((st.rail_ack & $past(st.rail_status))
                 == ($past(st.rail_status) & st.rail_status)))
    else $error("read of rail status did not acknowledge");
  a_lid_inverse: assert property (
    $fell(battery_lid_sense_in) ##1 !battery_lid_sense_in [*3]
    |-> ##[0:2] st.rail_status[6])
    else $error("lid low did not set rail bit 6");
  a_usb500_gate: assert property (
    usb_500ma_out |-> st.setup[pescc_pkg::SETUP_USB_ALLOW])
    else $error("500 mA limit active with USB barred");
  a_ac_preferred: assert property (
    !(charge_from_ac_out && charge_from_usb_out))
    else $error("both charge sources selected");
  a_unmapped_ff: assert property (
    reg_rd_in && (reg_addr_in == 8'h00) |=> reg_rdata_out == 8'hFF)
    else $error("unmapped read not FF");
  a_restart_pulse: assert property (
    reg_wr_in && (reg_addr_in == pescc_pkg::ADDR_SETUP) && reg_wdata_in[6]
    |=> charger_restart_out ##1 (!charger_restart_out || $past(reg_wr_in)))
    else $error("charger restart pulse missing");

  c_int_falls: cover property ($fell(event_int_n_out));
  c_button_event: cover property ($rose(st.rail_status[7]));
  c_ack_release: cover property (rd_chg ##[1:4] $rose(event_int_n_out));
  c_reset_pulse_end: cover property ($rose(reset_pulse_n_out));
endmodule

// >>> test/pescc_host_model.sv
`timescale 1ns/100ps
module pescc_host_model (
  // clock
  input  wire logic       clock_in,
  // register port
  input  wire logic [7:0] reg_rdata_in,
  output logic      [7:0] reg_addr_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic      [7:0] reg_wdata_out
);
  initial begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // one write strobe, taken at the rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = 1'b1;
    @(posedge clock_in);
    @(negedge clock_in);
    reg_wr_out    = 1'b0;
    reg_wdata_out = ~d;
  endtask
  // acknowledge registers are read here only to check them
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_in);
    reg_addr_out = a;
    reg_rd_out   = 1'b1;
    @(posedge clock_in);
    @(negedge clock_in);
    reg_rd_out   = 1'b0;
    reg_addr_out = ~a;
    @(posedge clock_in);
    d = reg_rdata_in;
  endtask
endmodule

// >>> test/test_pmic_event_status_and_charger_config.sv
`timescale 1ns/100ps
module test_pmic_event_status_and_charger_config;
  localparam int TICK = 10;
  logic       clock_in = 1'b0;
  logic       rst_in   = 1'b1;
  logic       link_clk = 1'b0;
  logic       req      = 1'b0;
  logic       en_a     = 1'b0;
  logic       en_b     = 1'b0;
  logic       core_off = 1'b0;
  logic [7:0] cond     = 8'h00;
  logic [7:0] rp       = 8'h00;
  logic [7:0] addr, wdata, rdata, d, v;
  logic [7:0] cs, rs, ca, ra, cm, rm, s, pc, pr;
  logic       wr, rd, int_n, rst_n, restart, tmr_en, u500, f_ac, f_usb;
  logic [1:0] cur;
  int         miscompares = 0;
  int         checks      = 0;
  int         cyc         = 0;
  int         seed        = 3881;

  always #4 clock_in = ~clock_in;
  always #62.5 link_clk = ~link_clk;

  pescc_top #(.TICK_CYCLES(TICK)) i_pescc_top (
    .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .charger_cond_in(cond),
    .shutdown_button_in(rp[7]), .battery_lid_sense_in(~rp[6]),
    .supply_undervoltage_in(rp[5]), .linreg_b_fault_in(rp[3]),
    .linreg_a_fault_in(rp[2]), .io_buck_fault_in(rp[1]),
    .cpu_buck_fault_in(rp[0]), .low_power_mode_in(rp[4]),
    .reset_request_in(req), .linreg_b_enable_in(en_b),
    .linreg_a_enable_in(en_a), .core_off_low_power_in(core_off),
    .event_int_n_out(int_n), .reset_pulse_n_out(rst_n),
    .charger_restart_out(restart), .safety_timer_en_out(tmr_en),
    .charge_current_sel_out(cur), .usb_500ma_out(u500),
    .charge_from_ac_out(f_ac), .charge_from_usb_out(f_usb));

  pescc_host_model i_pescc_host_model (
    .clock_in(clock_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata));

  task automatic close_out;
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  // reference model of status, acknowledge and edge memory
  task automatic m_step;
    logic [7:0] c, r;
    c  = cond & (s[5] ? 8'hFF : 8'hF3);
    r  = {rp[7:5], 1'b0, rp[3] & en_b, rp[2] & en_a, rp[1],
          rp[0] | (core_off & rp[4])};
    cs = (cs & 8'h21 & ~(~c & ca)) | (cs & 8'h1E & c)
       | (c & ~pc & 8'h3F) | (c & 8'hC0);
    ca = ca & cs;
    pc = c;
    rs = (rs & 8'hE0 & ~(~r & ra)) | (r & ~pr & 8'hE0) | (r & 8'h0F);
    ra = ra & rs;
    pr = r;
  endtask

  task automatic cmp_all;
    logic e;
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    e = ~|((cs & ~cm & ~ca) | (rs & ~rm & ~ra));
    check("int_n", int_n, e);
    check("timer_en", tmr_en, s[5]);
    check("cur_sel", cur, s[4:3]);
    check("usb500", u500, s[2] & s[1]);
    check("from_ac", f_ac, s[0] & cond[6]);
    check("from_usb", f_usb, s[0] & s[1] & cond[7] & ~cond[6]);
  endtask

  task automatic apply(input logic [7:0] c8, r8);
    @(negedge link_clk);
    @(negedge clock_in);
    cond = c8;
    rp   = r8;
    repeat (6) @(posedge clock_in);
    m_step;
    cmp_all;
  endtask

  task automatic rc(input logic [7:0] a);
    logic [7:0] e;
    e = (a == 8'h01) ? cs : (a == 8'h02) ? rs : (a == 8'h03) ? cm :
        (a == 8'h04) ? rm : (a == 8'h05) ? ca : (a == 8'h06) ? ra :
        (a == 8'h07) ? s : 8'hFF;
    i_pescc_host_model.rd(a, d);
    check("rdata", d, e);
    if (a == 8'h01) ca = ca | cs;
    if (a == 8'h02) ra = ra | rs;
    m_step;
    cmp_all;
  endtask

  task automatic wc(input logic [7:0] a, dv);
    i_pescc_host_model.wr(a, dv);
    check("restart", restart, a == 8'h01 || (a == 8'h07 && dv[6]));
    @(negedge clock_in);
    check("restart", restart, 1'b0);
    if (a == 8'h01) cs = cs & ~(~dv & 8'h1E);
    if (a == 8'h03) cm = dv;
    if (a == 8'h04) rm = dv;
    if (a == 8'h07) s = dv;
    m_step;
    cmp_all;
  endtask

  task automatic meas(input int ms);
    int n;
    logic ok;
    n = 0;
    while (rst_n !== 1'b1 && n < 2 * ms * TICK) begin
      @(posedge clock_in);
      n++;
    end
    ok = (n * 4 >= ms * TICK * 3) && (n * 4 <= ms * TICK * 5);
    check("pulse", ok, 1'b1);
  endtask

  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      close_out;
    end
  end

  initial begin
    {cs, rs, ca, ra, pc, pr} = '0;
    cm = 8'hFF;
    rm = 8'hFF;
    s  = 8'h1B;
    repeat (20) @(posedge clock_in);
    @(negedge clock_in);
    rst_in = 1'b0;
    meas(1000);
    for (int a = 0; a < 9; a++) rc(8'(a));
    wc(8'h02, 8'hFF);
    wc(8'h05, 8'hFF);
    wc(8'h06, 8'hFF);
    wc(8'h01, 8'hFF);
    for (int a = 1; a < 8; a++) rc(8'(a));
    for (int k = 0; k < 4; k++) begin
      v = 8'($random(seed));
      wc(8'h03 + 8'(k % 2), v);
      rc(8'h03 + 8'(k % 2));
    end
    wc(8'h07, 8'h3B);
    for (int i = 0; i < 8; i++) begin
      wc(8'h03, ~(8'h01 << i));
      apply(8'h01 << i, 8'h00);
      rc(8'h01);
      rc(8'h05);
      if (i >= 1 && i <= 4) begin
        wc(8'h01, 8'h00);
        rc(8'h01);
      end
      apply(8'h00, 8'h00);
      rc(8'h01);
      rc(8'h05);
    end
    en_a = 1'b1;
    en_b = 1'b1;
    wc(8'h03, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      wc(8'h04, ~(8'h01 << i));
      apply(8'h00, 8'h01 << i);
      rc(8'h02);
      rc(8'h06);
      apply(8'h00, 8'h00);
      rc(8'h02);
      rc(8'h06);
    end
    en_a = 1'b0;
    en_b = 1'b0;
    core_off = 1'b1;
    wc(8'h04, 8'h00);
    apply(8'h00, 8'h1C);
    rc(8'h02);
    apply(8'h00, 8'h00);
    rc(8'h02);
    wc(8'h03, 8'h00);
    apply(8'h01, 8'h80);
    rc(8'h01);
    rc(8'h02);
    apply(8'h00, 8'h00);
    rc(8'h01);
    rc(8'h02);
    for (int k = 0; k < 8; k++) begin
      v = 8'($random(seed));
      v[4:3] = k[1:0];
      apply(v & 8'hCC, 8'h00);
      wc(8'h07, v);
      if (v[6]) wc(8'h07, v & 8'hBF);
      rc(8'h07);
    end
    wc(8'h07, 8'h80);
    @(negedge clock_in);
    req = 1'b1;
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
    req = 1'b0;
    meas(69);
    close_out;
  end
endmodule
